// *** verilog/ccdc_pkg.sv ***
/*
 * Shared constants for the codec clock divider control block: register
 * indexes, field positions, reset values, masks and divider ratio decode.
 * Assumes one core clock domain; bit and gpio clock ratios are counted in system clock half periods.
 */
package ccdc_pkg;

   localparam logic [7:0] CCDC_CTL1_ADDR = 8'h28;
   localparam logic [7:0] CCDC_CTL2_ADDR = 8'h29;

   localparam logic [15:0] CCDC_CTL1_RESET = 16'h0040;
   localparam logic [15:0] CCDC_CTL2_RESET = 16'h0000;
   // implemented bits; all other bits read zero and ignore writes
   localparam logic [15:0] CCDC_CTL1_MASK = 16'hc9f7;
   localparam logic [15:0] CCDC_CTL2_MASK = 16'h8001;

   localparam int CCDC_TOUT_ENA_BIT = 15;
   localparam int CCDC_TOUT_RATE_BIT = 14;
   localparam int CCDC_SRC_SEL_BIT = 11;
   localparam int CCDC_PIN_DIV_BIT = 8;
   localparam int CCDC_BCLK_LSB = 4;
   localparam int CCDC_GPIO_LSB = 0;
   localparam int CCDC_FRAME_SEL_BIT = 15;
   localparam int CCDC_DIR_BIT = 0;

   localparam logic [3:0] CCDC_BCLK_RESET = 4'h4;
   localparam logic [2:0] CCDC_GPIO_RESET = 3'h0;

   // slow timeout clock division, as powers of two
   localparam int CCDC_TOUT_SLOW_LOG2 = 21;
   localparam int CCDC_TOUT_FAST_LOG2 = 19;

   localparam int CCDC_DIV_W = 7;
   typedef logic [CCDC_DIV_W-1:0] ccdc_half_t;

   // bit clock ratio as a count of system clock half periods
   function automatic ccdc_half_t ccdc_bclk_half(input logic [3:0] code);
      case (code)
         4'h0: ccdc_bclk_half = 7'h02;
         4'h1: ccdc_bclk_half = 7'h03;
         4'h2: ccdc_bclk_half = 7'h04;
         4'h3: ccdc_bclk_half = 7'h06;
         4'h4: ccdc_bclk_half = 7'h08;
         4'h5: ccdc_bclk_half = 7'h0b;
         4'h6: ccdc_bclk_half = 7'h0c;
         4'h7: ccdc_bclk_half = 7'h10;
         4'h8: ccdc_bclk_half = 7'h16;
         4'h9: ccdc_bclk_half = 7'h18;
         4'ha: ccdc_bclk_half = 7'h20;
         4'hb: ccdc_bclk_half = 7'h2c;
         4'hc: ccdc_bclk_half = 7'h30;
         default: ccdc_bclk_half = 7'h40;
      endcase
   endfunction

   // gpio clock ratio; reserved codes fall back to undivided
   function automatic ccdc_half_t ccdc_gpio_half(input logic [2:0] code);
      case (code)
         3'h1: ccdc_gpio_half = 7'h04;
         3'h2: ccdc_gpio_half = 7'h06;
         3'h3: ccdc_gpio_half = 7'h08;
         3'h4: ccdc_gpio_half = 7'h0b;
         3'h5: ccdc_gpio_half = 7'h0c;
         default: ccdc_gpio_half = 7'h02;
      endcase
   endfunction

endpackage

// *** verilog/ccdc_divider.sv ***
/*
 * Glitch-free programmable divider counting system clock half periods.
 * Assumes edge_tick pulses once per system clock edge, on core_clk.
 */
`timescale 1ns/100ps
module ccdc_divider #(
   parameter ccdc_pkg::ccdc_half_t RESET_HALF = 7'h02
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic edge_tick,
   input wire ccdc_pkg::ccdc_half_t half_count,
   output logic clk_out
);
   ccdc_pkg::ccdc_half_t cnt_reg, cnt_next, n_reg, n_next;
   logic out_reg, out_next;

   always_comb begin
      cnt_next = cnt_reg;
      n_next = n_reg;
      out_next = out_reg;
      if (edge_tick) begin
         // new ratio only taken at a period boundary
         if (cnt_reg == n_reg - 7'h01) begin //RULE_10
            cnt_next = '0;
            n_next = half_count;
         end else begin
            cnt_next = cnt_reg + 7'h01;
         end
         out_next = (cnt_next < (n_next >> 1));
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_reg <= '0;
         n_reg <= RESET_HALF;
         out_reg <= 1'b1;
      end else begin
         cnt_reg <= cnt_next;
         n_reg <= n_next;
         out_reg <= out_next;
      end
   end

   assign clk_out = out_reg;

   a_div_hold: assert property (@(posedge core_clk) disable iff (!resetn) //RULE_10
      !edge_tick |=> $stable(clk_out)) else $error("divider output moved without a tick");
   a_div_load: assert property (@(posedge core_clk) disable iff (!resetn) //RULE_10
      (edge_tick && cnt_reg != n_reg - 7'h01) |=> $stable(n_reg))
      else $error("divider ratio changed mid period");
endmodule

// *** verilog/ccdc_clock_control.sv ***
/*
 * Codec clock selection and division: system clock source, pin divide,
 * bit clock and gpio clock dividers, slow timeout clock, frame pin select
 * and master clock pin direction, with two 16-bit control registers.
 * Assumes a plain register port on core_clk and asynchronous clock pins
 * that are much slower than core_clk; derived clocks are sampled levels.
 */
// How it works
// [RULE_01] one enable bit runs or stops the slow timeout clock
// [RULE_02] rate bit picks system clock over 2^21 (0) or 2^19 (1)
// [RULE_03] source bit picks master clock pin (0) or locked loop (1)
// [RULE_04] pin-divide bit passes pin clock through (0) or halves it (1)
// [RULE_05] master-mode bit clock divides system clock per 4-bit code, reset four
// [RULE_06] gpio clock divides system clock per 3-bit code, reset undivided
// [RULE_07] master mode frame pin carries playback (0) or record (1) frame clock
// [RULE_08] direction bit makes master clock pin an input (0) or output (1)
// [RULE_09] unassigned register bits read zero and ignore writes
// [RULE_10] divider ratio changes apply only at period boundaries, no glitches
`timescale 1ns/100ps
module ccdc_clock_control #(
   parameter int TOUT_SLOW_LOG2 = ccdc_pkg::CCDC_TOUT_SLOW_LOG2,
   parameter int TOUT_FAST_LOG2 = ccdc_pkg::CCDC_TOUT_FAST_LOG2
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic master_clock_pin_in,
   output logic master_clock_pin_out,
   output logic master_clock_pin_oe,
   input wire logic frequency_locked_loop_clock,
   input wire logic master_mode,
   input wire logic playback_frame_clock,
   input wire logic record_frame_clock,
   output logic frame_pin_out,
   output logic frame_pin_oe,
   output logic codec_system_clock,
   output logic bit_clock,
   output logic gpio_output_clock,
   output logic slow_timeout_clock
);
   // register file
   logic [15:0] ctl1_reg, ctl1_next, ctl2_reg, ctl2_next, rdata_reg, rdata_next;

   always_comb begin
      ctl1_next = ctl1_reg;
      ctl2_next = ctl2_reg;
      rdata_next = '0;
      if (reg_wr && reg_addr == ccdc_pkg::CCDC_CTL1_ADDR) begin
         ctl1_next = reg_wdata & ccdc_pkg::CCDC_CTL1_MASK; //RULE_09
      end
      if (reg_wr && reg_addr == ccdc_pkg::CCDC_CTL2_ADDR) begin
         ctl2_next = reg_wdata & ccdc_pkg::CCDC_CTL2_MASK; //RULE_09
      end
      if (reg_rd) begin
         case (reg_addr)
            ccdc_pkg::CCDC_CTL1_ADDR: rdata_next = ctl1_reg;
            ccdc_pkg::CCDC_CTL2_ADDR: rdata_next = ctl2_reg;
            default: rdata_next = '0;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ctl1_reg <= ccdc_pkg::CCDC_CTL1_RESET;
         ctl2_reg <= ccdc_pkg::CCDC_CTL2_RESET;
         rdata_reg <= '0;
      end else begin
         ctl1_reg <= ctl1_next;
         ctl2_reg <= ctl2_next;
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;

   logic tout_ena, tout_fast, src_loop, pin_div2, frame_rec, pin_dir;
   assign tout_ena = ctl1_reg[ccdc_pkg::CCDC_TOUT_ENA_BIT];
   assign tout_fast = ctl1_reg[ccdc_pkg::CCDC_TOUT_RATE_BIT];
   assign src_loop = ctl1_reg[ccdc_pkg::CCDC_SRC_SEL_BIT];
   assign pin_div2 = ctl1_reg[ccdc_pkg::CCDC_PIN_DIV_BIT];
   assign frame_rec = ctl2_reg[ccdc_pkg::CCDC_FRAME_SEL_BIT];
   assign pin_dir = ctl2_reg[ccdc_pkg::CCDC_DIR_BIT];

   // pin and loop clocks are asynchronous: two flops each, then a history flop on the pin
   logic pin_s0, pin_s1, pin_prev, loop_s0, loop_s1;
   logic sys_reg, sys_next, sys_edge, sys_rise;

   always_comb begin
      sys_next = sys_reg;
      if (src_loop) begin
         sys_next = loop_s1; //RULE_03
      end else if (pin_dir) begin
         // the pin is our own output here, so it cannot feed the source
         sys_next = 1'b0; //RULE_08
      end else if (pin_div2) begin
         if (pin_s1 && !pin_prev) begin
            sys_next = !sys_reg; //RULE_04
         end
      end else begin
         sys_next = pin_s1; //RULE_04
      end
   end

   assign sys_edge = sys_next ^ sys_reg;
   assign sys_rise = sys_next & !sys_reg;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pin_s0 <= 1'b0;
         pin_s1 <= 1'b0;
         pin_prev <= 1'b0;
         loop_s0 <= 1'b0;
         loop_s1 <= 1'b0;
         sys_reg <= 1'b0;
      end else begin
         pin_s0 <= master_clock_pin_in;
         pin_s1 <= pin_s0;
         pin_prev <= pin_s1;
         loop_s0 <= frequency_locked_loop_clock;
         loop_s1 <= loop_s0;
         sys_reg <= sys_next;
      end
   end

   assign codec_system_clock = sys_reg;

   // slow timeout clock
   logic [TOUT_SLOW_LOG2-1:0] tout_cnt_reg, tout_cnt_next;
   logic tout_reg, tout_next;

   always_comb begin
      tout_cnt_next = tout_cnt_reg;
      if (!tout_ena) begin
         tout_cnt_next = '0; //RULE_01
      end else if (sys_rise) begin
         tout_cnt_next = tout_cnt_reg + 1'b1;
      end
      tout_next = tout_ena && (tout_fast ? tout_cnt_next[TOUT_FAST_LOG2-1] //RULE_02
                                         : tout_cnt_next[TOUT_SLOW_LOG2-1]);
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         tout_cnt_reg <= '0;
         tout_reg <= 1'b0;
      end else begin
         tout_cnt_reg <= tout_cnt_next;
         tout_reg <= tout_next;
      end
   end

   assign slow_timeout_clock = tout_reg;

   // bit clock and gpio clock dividers
   logic bclk_div, gpio_div;
   logic bclk_reg, bclk_next, frame_reg, frame_next, frame_oe_reg, mpin_reg, mpin_next;

   ccdc_divider #(
      .RESET_HALF(ccdc_pkg::ccdc_bclk_half(ccdc_pkg::CCDC_BCLK_RESET))
   ) u_bclk_div (
      .core_clk(core_clk),
      .resetn(resetn),
      .edge_tick(sys_edge),
      .half_count(ccdc_pkg::ccdc_bclk_half(ctl1_reg[ccdc_pkg::CCDC_BCLK_LSB +: 4])), //RULE_05
      .clk_out(bclk_div)
   );

   ccdc_divider #(
      .RESET_HALF(ccdc_pkg::ccdc_gpio_half(ccdc_pkg::CCDC_GPIO_RESET))
   ) u_gpio_div (
      .core_clk(core_clk),
      .resetn(resetn),
      .edge_tick(sys_edge),
      .half_count(ccdc_pkg::ccdc_gpio_half(ctl1_reg[ccdc_pkg::CCDC_GPIO_LSB +: 3])), //RULE_06
      .clk_out(gpio_div)
   );

   assign gpio_output_clock = gpio_div;

   always_comb begin
      bclk_next = master_mode && bclk_div; //RULE_05
      frame_next = master_mode && (frame_rec ? record_frame_clock //RULE_07
                                             : playback_frame_clock);
      mpin_next = pin_dir && sys_reg; //RULE_08
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         bclk_reg <= 1'b0;
         frame_reg <= 1'b0;
         frame_oe_reg <= 1'b0;
         mpin_reg <= 1'b0;
      end else begin
         bclk_reg <= bclk_next;
         frame_reg <= frame_next;
         frame_oe_reg <= master_mode;
         mpin_reg <= mpin_next;
      end
   end

   assign bit_clock = bclk_reg;
   assign frame_pin_out = frame_reg;
   assign frame_pin_oe = frame_oe_reg;
   assign master_clock_pin_out = mpin_reg;
   assign master_clock_pin_oe = pin_dir;

   // checks
   sequence s_ctl2_write;
      reg_wr && reg_addr == ccdc_pkg::CCDC_CTL2_ADDR;
   endsequence

   a_tout_gate: assert property (@(posedge core_clk) disable iff (!resetn) //RULE_01
      !tout_ena |=> !slow_timeout_clock) else $error("timeout clock ran while disabled");
   a_tout_rate: assert property (@(posedge core_clk) disable iff (!resetn) //RULE_02
      (tout_ena && tout_fast) |=> slow_timeout_clock == tout_cnt_reg[TOUT_FAST_LOG2-1])
      else $error("fast timeout clock not on fast counter tap");
   a_src_loop: assert property (@(posedge core_clk) disable iff (!resetn) //RULE_03
      src_loop |=> codec_system_clock == $past(loop_s1))
      else $error("system clock not from loop");
   a_pin_div1: assert property (@(posedge core_clk) disable iff (!resetn) //RULE_04
      (!src_loop && !pin_dir && !pin_div2) |=> codec_system_clock == $past(pin_s1))
      else $error("undivided pin clock not passed through");
   a_pin_div2: assert property (@(posedge core_clk) disable iff (!resetn) //RULE_04
      (!src_loop && !pin_dir && pin_div2 && !(pin_s1 && !pin_prev)) |=> $stable(sys_reg))
      else $error("halved pin clock moved without a pin rise");
   a_bclk_slave: assert property (@(posedge core_clk) disable iff (!resetn) //RULE_05
      !master_mode |=> !bit_clock) else $error("bit clock driven outside master mode");
   a_frame_sel: assert property (@(posedge core_clk) disable iff (!resetn) //RULE_07
      (master_mode && frame_rec) |=> frame_pin_out == $past(record_frame_clock))
      else $error("frame pin not carrying record frame clock");
   a_pin_dir: assert property (@(posedge core_clk) disable iff (!resetn) //RULE_08
      s_ctl2_write |=> master_clock_pin_oe == $past(reg_wdata[ccdc_pkg::CCDC_DIR_BIT]))
      else $error("pin direction not following control write");
   a_rsvd_zero: assert property (@(posedge core_clk) disable iff (!resetn) //RULE_09
      reg_rd |=> (reg_rdata & ~(($past(reg_addr) == ccdc_pkg::CCDC_CTL2_ADDR)
         ? ccdc_pkg::CCDC_CTL2_MASK : ccdc_pkg::CCDC_CTL1_MASK)) == '0)
      else $error("unassigned bits read nonzero");
endmodule

// *** tb/ccdc_far_end.sv ***
/*
 * Far-side model: external master clock source, loop clock and the two
 * frame clocks, all stepped on core_clk well below core_clk/4.
 * Assumes the bench resolves the master clock pin from the block's pin enable.
 */
`timescale 1ns/100ps
module ccdc_far_end #(
   parameter int PIN_HALF = 8,
   parameter int LOOP_HALF = 12
) (
   input wire logic core_clk,
   output logic pin_clk,
   output logic loop_clk,
   output logic playback,
   output logic record
);
   int cnt = 0;
   initial begin
      pin_clk = 1'b0;
      loop_clk = 1'b0;
      playback = 1'b0;
      record = 1'b0;
   end
   always @(posedge core_clk) begin
      cnt <= cnt + 1;
      if (cnt % PIN_HALF == 0) pin_clk <= ~pin_clk;
      if (cnt % LOOP_HALF == 0) loop_clk <= ~loop_clk;
      if (cnt % 3 == 0) playback <= ~playback;
      if (cnt % 5 == 0) record <= ~record;
   end
endmodule

// *** tb/tb.sv ***
/*
 * Self-checking bench for the clock control block: register port, clock
 * source, dividers, slow timeout clock, frame pin and pin direction.
 * Assumes a pin clock of 16 core cycles, so system clock periods are exact.
 */
`timescale 1ns/100ps
module tb;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic master_mode = 1'b0;
   logic [15:0] reg_rdata;
   logic pin_out, pin_oe, ext_pin, pin_wire, loop_clk, pb, rec, pb_d, rec_d;
   logic frame_pin_out, frame_pin_oe, codec_system_clock, bit_clock;
   logic gpio_output_clock, slow_timeout_clock;
   int bad_count = 0;
   int total_checks = 0;
   int bh [16] = '{2, 3, 4, 6, 8, 11, 12, 16, 22, 24, 32, 44, 48, 64, 64, 64};
   int gh [8] = '{2, 4, 6, 8, 11, 12, 2, 2};

   always #20 core_clk = ~core_clk;
   // wire level of the master clock pin from both parties
   assign pin_wire = pin_oe ? pin_out : ext_pin;
   always @(posedge core_clk) begin
      pb_d <= pb;
      rec_d <= rec;
   end

   ccdc_far_end far (.core_clk(core_clk), .pin_clk(ext_pin), .loop_clk(loop_clk),
      .playback(pb), .record(rec));
   ccdc_clock_control #(.TOUT_SLOW_LOG2(5), .TOUT_FAST_LOG2(3)) dut (
      .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .master_clock_pin_in(pin_wire),
      .master_clock_pin_out(pin_out), .master_clock_pin_oe(pin_oe),
      .frequency_locked_loop_clock(loop_clk), .master_mode(master_mode),
      .playback_frame_clock(pb), .record_frame_clock(rec),
      .frame_pin_out(frame_pin_out), .frame_pin_oe(frame_pin_oe),
      .codec_system_clock(codec_system_clock), .bit_clock(bit_clock),
      .gpio_output_clock(gpio_output_clock), .slow_timeout_clock(slow_timeout_clock));

   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_per(input int got, input int exp);
      check_val(got[15:0], exp[15:0]);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      d = reg_rdata;
   endtask
   function automatic logic pick(input int s);
      case (s)
         0: pick = codec_system_clock;
         1: pick = bit_clock;
         2: pick = gpio_output_clock;
         3: pick = slow_timeout_clock;
         default: pick = pin_out;
      endcase
   endfunction
   // cycles between two rising edges, second period after a change
   task automatic measure(input int s, output int per);
      int n, edges;
      logic prev;
      edges = 0;
      per = 0;
      @(negedge core_clk);
      prev = pick(s);
      for (n = 0; n < 4000 && edges < 3; n++) begin
         @(negedge core_clk);
         per++;
         if (pick(s) === 1'b1 && prev === 1'b0) begin
            edges++;
            if (edges < 3) per = 0;
         end
         prev = pick(s);
      end
      if (edges < 3) begin
         bad_count++;
         results();
      end
   endtask
   task automatic hold_low(input int s, input int n);
      repeat (n) begin
         @(negedge core_clk);
         check_val({15'h0000, pick(s)}, 16'h0000);
      end
   endtask

   task automatic t_regs();
      logic [15:0] d;
      rd(8'h28, d); check_val(d, 16'h0040);
      rd(8'h29, d); check_val(d, 16'h0000);
      wr(8'h30, 16'hffff);
      rd(8'h30, d); check_val(d, 16'h0000);
      wr(8'h28, 16'hffff);
      wr(8'h29, 16'hffff);
      rd(8'h28, d); check_val(d, 16'hc9f7);
      rd(8'h29, d); check_val(d, 16'h8001);
      wr(8'h29, 16'h0000);
   endtask
   task automatic t_src();
      int p;
      wr(8'h28, 16'h0000); measure(0, p); check_per(p, 16);
      wr(8'h28, 16'h0100); measure(0, p); check_per(p, 32);
      wr(8'h28, 16'h0800); measure(0, p); check_per(p, 24);
   endtask
   task automatic t_div();
      int p;
      @(posedge core_clk);
      master_mode <= 1'b1;
      for (int c = 0; c < 16; c++) begin
         wr(8'h28, 16'(c << 4)); measure(1, p); check_per(p, bh[c] * 8);
      end
      for (int c = 0; c < 8; c++) begin
         wr(8'h28, 16'(c)); measure(2, p); check_per(p, gh[c] * 8);
      end
      @(posedge core_clk);
      master_mode <= 1'b0;
      repeat (3) @(negedge core_clk);
      hold_low(1, 200);
   endtask
   task automatic t_slow();
      int p;
      wr(8'h28, 16'h0000); hold_low(3, 600);
      wr(8'h28, 16'h8000); measure(3, p); check_per(p, 512);
      wr(8'h28, 16'hc000); measure(3, p); check_per(p, 128);
      wr(8'h28, 16'h0000);
      // the slow clock register takes one more edge to see the cleared enable
      @(posedge core_clk);
      hold_low(3, 600);
   endtask
   task automatic t_frame();
      @(posedge core_clk);
      master_mode <= 1'b1;
      for (int s = 0; s < 2; s++) begin
         wr(8'h29, 16'(s << 15));
         // frame pin register picks up the new select one edge after the write
         @(posedge core_clk);
         repeat (20) begin
            @(negedge core_clk);
            check_val({14'h0000, frame_pin_oe, frame_pin_out}, {14'h0000, 1'b1, s ? rec_d : pb_d});
         end
      end
      @(posedge core_clk);
      master_mode <= 1'b0;
      repeat (3) @(negedge core_clk);
      check_val({14'h0000, frame_pin_oe, frame_pin_out}, 16'h0000);
   endtask
   task automatic t_dir();
      int p;
      wr(8'h28, 16'h0800);
      wr(8'h29, 16'h0001);
      @(negedge core_clk);
      check_val({15'h0000, pin_oe}, 16'h0001);
      measure(4, p); check_per(p, 24);
      wr(8'h29, 16'h0000);
      wr(8'h28, 16'h0000);
      @(negedge core_clk);
      check_val({15'h0000, pin_oe}, 16'h0000);
      measure(0, p); check_per(p, 16);
   endtask

   initial begin
      repeat (10) @(posedge core_clk);
      resetn <= 1'b1;
      t_regs();
      t_src();
      t_div();
      t_slow();
      t_frame();
      t_dir();
      results();
   end
endmodule
